// ===== logic/crte_pkg.sv
// Purpose: shared constants and carriers for the command interpreter slice
// Assumes: byte frames of nine bytes, one motor, one clock domain
// Notes: the rule summary below describes the behaviour of the logic files
//
// Summary of operation
// - return from interrupt restores saved context
// - restore only from stored program, not host
// - opcodes 64..71 reserved, reply status 100
// - opcode 138: immediate reply, later reached reply
// - opcode 138 accepted only from host
// - type 0 arms next move only
// - type 1 arms every following move
// - immediate reply: 64h, 8Ah, mask byte
// - reached reply: 80h, 8Ah, mask byte
// - reply order: 01h, 02h, status, command, value, sum
package crte_pkg;

  localparam logic [7:0] OPC_RETURN_IRQ = 8'd38;
  localparam logic [7:0] OPC_USER_FIRST = 8'd64;
  localparam logic [7:0] OPC_USER_LAST = 8'd71;
  localparam logic [7:0] OPC_POS_EVENT = 8'd138;
  localparam logic [7:0] STATUS_OK = 8'd100;
  localparam logic [7:0] STATUS_REACHED = 8'd128;
  localparam logic [7:0] REPLY_ADDR = 8'h01;
  localparam logic [7:0] REPLY_MODULE_ADDR = 8'h02;
  localparam logic [7:0] RX_MODULE_ADDR = 8'h01;
  localparam logic [7:0] TYPE_NEXT_ONLY = 8'h00;
  localparam logic [7:0] TYPE_EVERY = 8'h01;
  localparam logic [3:0] FRAME_LAST = 4'h8;

  // decoded command fields
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] ctype;
    logic [7:0] motor;
    logic [31:0] value;
  } crte_cmd_s;

  // program context saved on interrupt entry
  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] xreg;
    logic [7:0] flags;
    logic [15:0] pc;
  } crte_ctx_s;

  // reply fields that vary between frames
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] command;
    logic [31:0] value;
  } crte_reply_s;

endpackage

// ===== logic/crte_frame_tx.sv
// Purpose: serialise one reply frame of nine bytes
// Assumes: byte sink with valid/ready handshake on the same clock
// Notes: start_i is honoured only while idle_o is high
`timescale 1ns/1ps
module crte_frame_tx
  import crte_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire crte_reply_s reply_i,
  output logic idle_o,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i
);

  logic [3:0] idx_reg;
  logic [7:0] sum_reg;
  crte_reply_s rep_reg;
  logic [7:0] byte_next;

  // pick the byte for the current position
  always_comb begin
    unique case (idx_reg)
      4'h0: byte_next = REPLY_ADDR;
      4'h1: byte_next = REPLY_MODULE_ADDR;
      4'h2: byte_next = rep_reg.status;
      4'h3: byte_next = rep_reg.command;
      4'h4: byte_next = rep_reg.value[31:24];
      4'h5: byte_next = rep_reg.value[23:16];
      4'h6: byte_next = rep_reg.value[15:8];
      4'h7: byte_next = rep_reg.value[7:0];
      default: byte_next = sum_reg;
    endcase
  end

  // frame walk: load, present byte, advance on accept
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      idx_reg <= 4'h0;
      sum_reg <= 8'h00;
      rep_reg <= '0;
      idle_o <= 1'b1;
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
    end else if (idle_o) begin
      if (start_i) begin
        rep_reg <= reply_i;
        idx_reg <= 4'h0;
        sum_reg <= 8'h00;
        idle_o <= 1'b0;
      end
    end else if (!tx_valid_o) begin
      tx_data_o <= byte_next;
      tx_valid_o <= 1'b1;
    end else if (tx_ready_i) begin
      tx_valid_o <= 1'b0;
      sum_reg <= sum_reg + tx_data_o;
      if (idx_reg == FRAME_LAST) begin
        idle_o <= 1'b1;
      end
      idx_reg <= idx_reg + 4'h1;
    end
  end

endmodule

// ===== logic/crte_cmd_interp.sv
// Purpose: interpret return, user-function and position-event commands
// Assumes: host bytes and program commands come from same-clock logic
// Notes: a new host frame replaces an immediate reply not yet started, or drops it if its opcode has no reply
`timescale 1ns/1ps
module crte_cmd_interp
  import crte_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  // host command bytes from the serial receiver
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  // reply bytes to the serial transmitter
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  // commands fetched by the stored-program engine
  input wire logic prog_valid_i,
  input wire crte_cmd_s prog_cmd_i,
  // interrupt entry with the context to save
  input wire logic irq_enter_i,
  input wire crte_ctx_s ctx_i,
  output logic restore_o,
  output crte_ctx_s ctx_o,
  // user function slots
  input wire logic [31:0] user_value_i,
  output logic user_fn_o,
  output logic [2:0] user_slot_o,
  // motion engine events
  input wire logic move_to_position_i,
  input wire logic target_reached_i,
  // diagnostics
  output logic csum_err_o,
  output logic prog_reject_o,
  output logic [7:0] frame_cnt_o
);

  logic [7:0] rx_buf [0:7];
  logic [3:0] rx_cnt_reg;
  logic [7:0] rx_sum_reg;
  logic frame_reg;
  crte_cmd_s host_cmd_reg;
  crte_ctx_s saved_reg;
  logic imm_pend_reg;
  crte_reply_s imm_reply_reg;
  logic arm_reg;
  logic arm_every_reg;
  logic [7:0] mask_reg;
  logic wait_reg;
  logic evt_pend_reg;
  logic tx_start_reg;
  crte_reply_s tx_reply_reg;
  logic tx_idle;
  logic evt_taken;
  logic imm_taken;

  // true for the reserved user-function opcode range
  function automatic logic is_user_op(input logic [7:0] op);
    return (op >= OPC_USER_FIRST) && (op <= OPC_USER_LAST);
  endfunction

  // collect nine bytes; the ninth is compared with the running sum
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_cnt_reg <= 4'h0;
      rx_sum_reg <= 8'h00;
      frame_reg <= 1'b0;
      csum_err_o <= 1'b0;
      host_cmd_reg <= '0;
    end else begin
      frame_reg <= 1'b0;
      csum_err_o <= 1'b0;
      if (rx_valid_i) begin
        if (rx_cnt_reg == FRAME_LAST) begin
          rx_cnt_reg <= 4'h0;
          rx_sum_reg <= 8'h00;
          if (rx_data_i != rx_sum_reg) begin
            csum_err_o <= 1'b1;
          end else if (rx_buf[0] == RX_MODULE_ADDR) begin
            frame_reg <= 1'b1;
            host_cmd_reg <= '{opcode: rx_buf[1], ctype: rx_buf[2],
                              motor: rx_buf[3],
                              value: {rx_buf[4], rx_buf[5],
                                      rx_buf[6], rx_buf[7]}};
          end
        end else begin
          rx_cnt_reg <= rx_cnt_reg + 4'h1;
          rx_sum_reg <= rx_sum_reg + rx_data_i;
        end
      end
    end
  end

  // byte store for the eight leading frame bytes
  always_ff @(posedge mclk_i) begin
    if (rx_valid_i && (rx_cnt_reg != FRAME_LAST)) begin
      rx_buf[rx_cnt_reg[2:0]] <= rx_data_i;
    end
  end

  // count accepted frames for diagnostics
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      frame_cnt_o <= 8'h00;
    end else if (frame_reg) begin
      frame_cnt_o <= frame_cnt_o + 8'h01;
    end
  end

  // context save on interrupt entry, restore on program return
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      saved_reg <= '0;
      restore_o <= 1'b0;
      ctx_o <= '0;
    end else begin
      restore_o <= 1'b0;
      if (irq_enter_i) begin
        saved_reg <= ctx_i;
      end
      // handlers are expected to end here, never fall into
      if (prog_valid_i && prog_cmd_i.opcode == OPC_RETURN_IRQ) begin
        restore_o <= 1'b1;
        ctx_o <= saved_reg;
      end
    end
  end

  // user-function slots from either source; position request from program
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      user_fn_o <= 1'b0;
      user_slot_o <= 3'h0;
      prog_reject_o <= 1'b0;
    end else begin
      user_fn_o <= 1'b0;
      prog_reject_o <= 1'b0;
      if (prog_valid_i && is_user_op(prog_cmd_i.opcode)) begin
        user_fn_o <= 1'b1;
        user_slot_o <= prog_cmd_i.opcode[2:0];
      end else if (frame_reg && is_user_op(host_cmd_reg.opcode)) begin
        user_fn_o <= 1'b1;
        user_slot_o <= host_cmd_reg.opcode[2:0];
      end
      if (prog_valid_i && prog_cmd_i.opcode == OPC_POS_EVENT) begin
        prog_reject_o <= 1'b1;
      end
    end
  end

  // immediate direct-mode replies
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      imm_pend_reg <= 1'b0;
      imm_reply_reg <= '0;
    end else if (frame_reg) begin
      imm_pend_reg <= 1'b0;
      if (host_cmd_reg.opcode == OPC_POS_EVENT) begin
        imm_pend_reg <= 1'b1;
        imm_reply_reg <= '{status: STATUS_OK, command: OPC_POS_EVENT,
                           value: {24'h00_0000,
                                   host_cmd_reg.value[7:0]}};
      end else if (is_user_op(host_cmd_reg.opcode)) begin
        imm_pend_reg <= 1'b1;
        imm_reply_reg <= '{status: STATUS_OK,
                           command: host_cmd_reg.opcode,
                           value: user_value_i};
      end else if (host_cmd_reg.opcode == OPC_RETURN_IRQ) begin
        // host form only acknowledges; no context is touched
        imm_pend_reg <= 1'b1;
        imm_reply_reg <= '{status: STATUS_OK,
                           command: OPC_RETURN_IRQ,
                           value: 32'h0000_0000};
      end
    end else if (imm_taken) begin
      imm_pend_reg <= 1'b0;
    end
  end

  // arming of the position-reached notification
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      arm_reg <= 1'b0;
      arm_every_reg <= 1'b0;
      mask_reg <= 8'h00;
    end else if (frame_reg && host_cmd_reg.opcode == OPC_POS_EVENT) begin
      // the mask is taken as sent; a single-axis host sends 1
      mask_reg <= host_cmd_reg.value[7:0];
      arm_reg <= 1'b1;
      arm_every_reg <= (host_cmd_reg.ctype == TYPE_EVERY);
    end else if (move_to_position_i && !arm_every_reg) begin
      arm_reg <= 1'b0;
    end
  end

  // watch the armed move, then queue the notification
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wait_reg <= 1'b0;
      evt_pend_reg <= 1'b0;
    end else begin
      if (move_to_position_i && arm_reg) begin
        wait_reg <= 1'b1;
      end else if (target_reached_i && wait_reg) begin
        wait_reg <= 1'b0;
      end
      // a new arrival wins over the clear by the sender
      if (target_reached_i && wait_reg) begin
        evt_pend_reg <= 1'b1;
      end else if (evt_taken) begin
        evt_pend_reg <= 1'b0;
      end
    end
  end

  assign imm_taken = tx_idle && !tx_start_reg && imm_pend_reg;
  assign evt_taken = tx_idle && !tx_start_reg && !imm_pend_reg &&
                     evt_pend_reg;

  // reply arbitration: immediate first, notification after
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tx_start_reg <= 1'b0;
      tx_reply_reg <= '0;
    end else begin
      tx_start_reg <= 1'b0;
      if (imm_taken) begin
        tx_start_reg <= 1'b1;
        tx_reply_reg <= imm_reply_reg;
      end else if (evt_taken) begin
        tx_start_reg <= 1'b1;
        tx_reply_reg <= '{status: STATUS_REACHED,
                          command: OPC_POS_EVENT,
                          value: {24'h00_0000, mask_reg}};
      end
    end
  end

  // reply serializer
  crte_frame_tx u_tx (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(tx_start_reg),
    .reply_i(tx_reply_reg),
    .idle_o(tx_idle),
    .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i)
  );

endmodule

// ===== dv/crte_cmd_interp_chk.sv
// Purpose: port assertions for the command interpreter
// Assumes: one clock, synchronous active-high reset
// Notes: bound to crte_cmd_interp below the module
`timescale 1ns/1ps
module crte_cmd_interp_chk
  import crte_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic prog_valid_i,
  input wire crte_cmd_s prog_cmd_i,
  input wire logic irq_enter_i,
  input wire crte_ctx_s ctx_i,
  input wire logic restore_o,
  input wire crte_ctx_s ctx_o,
  input wire logic user_fn_o,
  input wire logic [2:0] user_slot_o,
  input wire logic csum_err_o,
  input wire logic prog_reject_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  crte_ctx_s saved_reg;
  logic [3:0] idx_reg;
  logic [7:0] op;
  logic [2:0] slot;
  assign op = prog_cmd_i.opcode;
  assign slot = op[2:0];
  // shadow of the context saved on interrupt entry
  always_ff @(posedge mclk_i) begin
    if (rst_i)
      saved_reg <= '0;
    else if (irq_enter_i)
      saved_reg <= ctx_i;
  end
  // byte position inside the reply frame
  always_ff @(posedge mclk_i) begin
    if (rst_i || (tx_valid_o && tx_ready_i && idx_reg == FRAME_LAST))
      idx_reg <= 4'h0;
    else if (tx_valid_o && tx_ready_i)
      idx_reg <= idx_reg + 4'h1;
  end
  sequence prog_op(logic [7:0] o);
    prog_valid_i && op == o;
  endsequence
  restore_ctx_a: assert property (prog_op(OPC_RETURN_IRQ) |=>
    restore_o && ctx_o == $past(saved_reg)) else $error("bad restore");
  restore_src_a: assert property (restore_o |-> $past(prog_valid_i)
    && $past(op) == OPC_RETURN_IRQ) else $error("stray restore");
  user_slot_a: assert property (prog_valid_i && op >= OPC_USER_FIRST
    && op <= OPC_USER_LAST |=> user_fn_o && user_slot_o == $past(slot))
    else $error("bad user slot");
  prog_rej_a: assert property (prog_op(OPC_POS_EVENT) |=>
    prog_reject_o && !restore_o) else $error("no reject");
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o)) else $error("byte dropped");
  tx_gap_a: assert property (tx_valid_o && tx_ready_i |=>
    !tx_valid_o) else $error("no idle gap");
  frame_head_a: assert property (tx_valid_o && idx_reg < 4'h2 |->
    tx_data_o == (idx_reg == 4'h0 ? REPLY_ADDR : REPLY_MODULE_ADDR))
    else $error("bad frame head");
  sum_err_a: assert property (csum_err_o |-> $past(rx_valid_i)
    || $past(rx_valid_i, 2)) else $error("stray sum error");
endmodule
bind crte_cmd_interp crte_cmd_interp_chk i_chk (.mclk_i, .rst_i,
  .rx_valid_i, .tx_data_o, .tx_valid_o, .tx_ready_i, .prog_valid_i,
  .prog_cmd_i, .irq_enter_i, .ctx_i, .restore_o, .ctx_o, .user_fn_o,
  .user_slot_o, .csum_err_o, .prog_reject_o);

// ===== dv/crte_host_model.sv
// Purpose: host end of the serial link, sends frames, takes replies
// Assumes: drives one nanosecond after the rising edge
// Notes: slow makes the reply sink stall every other cycle
`timescale 1ns/1ps
module crte_host_model (
  input wire logic mclk_i,
  output logic [7:0] rx_data_o = 8'h00,
  output logic rx_valid_o = 1'b0,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o = 1'b0
);
  logic [7:0] got[$];
  logic slow = 1'b0;
  // collect reply bytes; ready toggles while slow
  always @(posedge mclk_i) begin
    if (tx_valid_i && tx_ready_o)
      got.push_back(tx_data_i);
    tx_ready_o <= #1 slow ? ~tx_ready_o : 1'b1;
  end
  // nine bytes back to back, sum last; bad corrupts it
  task automatic send(input logic [63:0] head, input logic bad);
    logic [7:0] b;
    logic [7:0] sum;
    sum = 8'h00;
    for (int i = 0; i < 9; i++) begin
      b = i < 8 ? head[63-8*i -: 8] : sum ^ {7'h00, bad};
      sum = sum + b;
      @(posedge mclk_i);
      #1;
      rx_data_o = b;
      rx_valid_o = 1'b1;
    end
    @(posedge mclk_i);
    #1;
    rx_valid_o = 1'b0;
    rx_data_o = ~rx_data_o;
  endtask
endmodule

// ===== dv/crte_cmd_interp_tb_top.sv
// Purpose: self-checking bench for the command interpreter
// Assumes: host model on the link, bench drives program side
// Notes: one task per scenario
`timescale 1ns/1ps
module crte_cmd_interp_tb_top
  import crte_pkg::*;
;
  logic mclk_i, rst_i = 1'b1;
  logic [7:0] rx_data_i, tx_data_o, frame_cnt_o;
  logic rx_valid_i, tx_valid_o, tx_ready_i, restore_o, user_fn_o;
  logic prog_valid_i = 1'b0, irq_enter_i = 1'b0;
  logic move_to_position_i = 1'b0, target_reached_i = 1'b0;
  logic csum_err_o, prog_reject_o;
  logic [2:0] user_slot_o;
  logic [31:0] user_value_i = 32'h0000_0000;
  crte_cmd_s prog_cmd_i = '0;
  crte_ctx_s ctx_i = '0, ctx_o;
  int errors = 0, n_checks = 0, cyc = 0;
  crte_cmd_interp i_crte_cmd_interp (.mclk_i, .rst_i, .rx_data_i,
    .rx_valid_i, .tx_data_o, .tx_valid_o, .tx_ready_i, .prog_valid_i,
    .prog_cmd_i, .irq_enter_i, .ctx_i, .restore_o, .ctx_o, .user_value_i,
    .user_fn_o, .user_slot_o, .move_to_position_i, .target_reached_i,
    .csum_err_o, .prog_reject_o, .frame_cnt_o);
  crte_host_model i_crte_host_model (.mclk_i, .rx_data_o(rx_data_i),
    .rx_valid_o(rx_valid_i), .tx_data_i(tx_data_o),
    .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    @(posedge mclk_i);
    #1;
    s = 1'b1;
    @(posedge mclk_i);
    #1;
    s = 1'b0;
  endtask
  task automatic prog(input logic [7:0] op);
    @(posedge mclk_i);
    #1;
    prog_cmd_i = {op, 8'hff, 8'h00, 32'h0000_0000};
    prog_valid_i = 1'b1;
    @(posedge mclk_i);
    #1;
    prog_valid_i = 1'b0;
  endtask
  task automatic host(input logic [7:0] op, input logic [7:0] ty,
                      input logic bad);
    i_crte_host_model.send({8'h01, op, ty, 8'h00, 32'h0000_0001}, bad);
  endtask
  task automatic reply(input logic [7:0] st, input logic [7:0] cmd,
                       input logic [31:0] v);
    logic [71:0] e;
    e = {REPLY_ADDR, REPLY_MODULE_ADDR, st, cmd, v, 8'h00};
    for (int k = 0; k < 8; k++)
      e[7:0] = e[7:0] + e[71-8*k -: 8];
    for (int k = 0; k < 400 && i_crte_host_model.got.size() < 9; k++)
      @(posedge mclk_i);
    chk(i_crte_host_model.got.size(), 9);
    for (int k = 0; k < 9 && i_crte_host_model.got.size() > 0; k++)
      chk(i_crte_host_model.got.pop_front(), e[71-8*k -: 8]);
  endtask
  task automatic quiet;
    repeat (60) @(posedge mclk_i);
    chk(i_crte_host_model.got.size(), 0);
  endtask
  task automatic s_return_from_interrupt;
    ctx_i = {32'h1234_5678, 32'h9abc_def0, 8'h5a, 16'h0c0d};
    pulse(irq_enter_i);
    prog(OPC_RETURN_IRQ);
    chk(restore_o, 1);
    chk(ctx_o.pc, 16'h0c0d);
    chk(ctx_o.acc, 32'h1234_5678);
    chk(ctx_o.xreg, 32'h9abc_def0);
    chk(ctx_o.flags, 8'h5a);
    host(OPC_RETURN_IRQ, 8'hff, 1'b0);
    reply(STATUS_OK, OPC_RETURN_IRQ, 0);
  endtask
  task automatic s_user;
    logic [7:0] n;
    for (int i = 0; i < 8; i++) begin
      prog(OPC_USER_FIRST + i[7:0]);
      chk(user_fn_o, 1);
      chk(user_slot_o, i[2:0]);
    end
    user_value_i = 32'hcafe_0042;
    n = frame_cnt_o;
    host(OPC_USER_LAST, 8'h00, 1'b0);
    reply(STATUS_OK, OPC_USER_LAST, 32'hcafe_0042);
    chk(frame_cnt_o, n + 8'h01);
  endtask
  task automatic s_event(input logic [7:0] ty);
    i_crte_host_model.slow = ty[0];
    host(OPC_POS_EVENT, ty, 1'b0);
    reply(STATUS_OK, OPC_POS_EVENT, 1);
    for (int i = 0; i < 2; i++) begin
      pulse(move_to_position_i);
      pulse(target_reached_i);
      if (ty == TYPE_EVERY || i == 0)
        reply(STATUS_REACHED, OPC_POS_EVENT, 1);
      else
        quiet();
    end
    i_crte_host_model.slow = 1'b0;
  endtask
  task automatic s_faults;
    logic [7:0] n;
    logic seen;
    prog(OPC_POS_EVENT);
    chk(prog_reject_o, 1);
    quiet();
    n = frame_cnt_o;
    seen = 1'b0;
    host(OPC_POS_EVENT, TYPE_EVERY, 1'b1);
    // the error pulse stands in the cycle right after the ninth byte
    repeat (3) begin
      seen = seen | csum_err_o;
      @(posedge mclk_i);
      #1;
    end
    chk(seen, 1);
    chk(frame_cnt_o, n);
    quiet();
    // good sum but another module address: dropped without a reply
    i_crte_host_model.send({8'h05, OPC_POS_EVENT, TYPE_EVERY, 8'h00,
                            32'h0000_0001}, 1'b0);
    quiet();
    chk(frame_cnt_o, n);
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    s_return_from_interrupt();
    s_user();
    s_event(TYPE_EVERY);
    s_event(TYPE_NEXT_ONLY);
    s_faults();
    give_verdict();
  end
endmodule
